// file: rtl/scpll_pkg.sv
// scpll_pkg: shared constants, types and helpers for the sync clock
// and reference clock configuration block.
// assumes a single 250 MHz clock domain and a 32-bit Avalon-MM slave.
package scpll_pkg;

  // register indices; byte address is four times the index
  localparam logic [7:0] IDX_MODE_OUT = 8'h01;
  localparam logic [7:0] IDX_PLL_CLK = 8'h02;
  localparam logic [7:0] IDX_STATUS = 8'h08;
  localparam logic [7:0] ADR_MODE_OUT = 8'(IDX_MODE_OUT * 4);
  localparam logic [7:0] ADR_PLL_CLK = 8'(IDX_PLL_CLK * 4);
  localparam logic [7:0] ADR_STATUS = 8'(IDX_STATUS * 4);

  // mode_output_config field positions
  localparam int BIT_RAMP_OVER_EN = 13;
  localparam int BIT_SYNC_EN = 11;
  localparam int BIT_SYNC_INV = 10;

  // pll_clock_config field positions
  localparam int BIT_DIV_RST = 22;
  localparam int BIT_DIV_LO = 20;
  localparam int BIT_DBL_EN = 19;
  localparam int BIT_PLL_EN = 18;
  localparam int BIT_DIV_EN = 17;
  localparam int BIT_DBL_EDGE = 16;

  // reset values and implemented-bit masks (other bits read as zero)
  localparam logic [31:0] MODE_OUT_RST = 32'h0000_0800;
  localparam logic [31:0] MODE_OUT_MASK = 32'h0000_2C00;
  localparam logic [31:0] PLL_CLK_RST = 32'h0000_0000;
  localparam logic [31:0] PLL_CLK_MASK = 32'h003F_0000;

  // status field positions
  localparam int ST_PLL_ON = 0;
  localparam int ST_DBL_ON = 1;
  localparam int ST_DIV_BYP = 2;
  localparam int ST_DIV_BUSY = 3;
  localparam int ST_SYNC_INT = 4;
  localparam int ST_DIV_LO = 5;

  // cycle counts
  localparam logic [2:0] DIV_RST_CYCLES = 3'h4;
  localparam logic [3:0] SYNC_HALF_CYCLES = 4'h4;

  // bus handshake states
  typedef enum logic [1:0] {
    BUS_IDLE = 2'b01,
    BUS_ACK = 2'b10
  } scpll_bus_t;

  // merge write data into a register under byte enables
  function automatic logic [31:0] be_merge(input logic [31:0] old_v,
      input logic [31:0] new_v, input logic [3:0] be);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // last count of the input divider for a two-bit code
  function automatic logic [2:0] div_last(input logic [1:0] code);
    return 3'((4'h1 << code) - 4'h1);
  endfunction

endpackage

// file: rtl/scpll_ref_div.sv
// scpll_ref_div: reference clock input divider with doubler and reset.
// assumes ref_pin is asynchronous and much slower than the clock.
module scpll_ref_div
  import scpll_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // reference pin and controls
  input wire logic ref_pin,
  input wire logic div_en,
  input wire logic [1:0] div_code,
  input wire logic dbl_on,
  input wire logic div_rst,
  // results
  output logic ref_tick,
  output logic busy
);

  logic s1_reg, s2_reg, s3_reg; // three-stage pin sampler
  logic filt_reg; // level accepted when stages two and three agree
  logic [2:0] cnt_reg; // divide counter
  logic [2:0] rst_cnt_reg; // remaining divider reset cycles
  logic edge_w; // qualified reference edge
  logic [2:0] last_w; // terminal count

  // sampler; stage one feeds stage two only
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      s1_reg <= 1'b0;
      s2_reg <= 1'b0;
      s3_reg <= 1'b0;
      filt_reg <= 1'b0;
    end else begin
      s1_reg <= ref_pin;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      if (s2_reg == s3_reg) begin
        filt_reg <= s3_reg;
      end
    end
  end

  // doubler counts both edges, otherwise rising only
  assign edge_w = (s3_reg != filt_reg) && (s2_reg == s3_reg) &&
                  (dbl_on || s3_reg);
  // bypassed divider behaves as divide by one
  assign last_w = div_en ? div_last(div_code) : 3'h0;

  // divider reset holds the counter cleared for a few cycles
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      rst_cnt_reg <= 3'h0;
    end else if (div_rst) begin
      rst_cnt_reg <= DIV_RST_CYCLES;
    end else if (rst_cnt_reg != 3'h0) begin
      rst_cnt_reg <= rst_cnt_reg - 3'h1;
    end
  end

  // divide counter and output tick
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      cnt_reg <= 3'h0;
      ref_tick <= 1'b0;
    end else if (busy || div_rst) begin
      cnt_reg <= 3'h0;
      ref_tick <= 1'b0;
    end else begin
      ref_tick <= edge_w && (cnt_reg >= last_w);
      if (edge_w) begin
        cnt_reg <= (cnt_reg >= last_w) ? 3'h0 : cnt_reg + 3'h1;
      end
    end
  end

  assign busy = (rst_cnt_reg != 3'h0);

endmodule

// file: rtl/scpll_sync_out.sv
// scpll_sync_out: internal sync clock and its gated, polarised pin.
// assumes an enable pulse rate set by a fixed half-period count.
module scpll_sync_out
  import scpll_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // controls
  input wire logic sync_en,
  input wire logic sync_inv,
  // outputs
  output logic sync_int,
  output logic sync_pin
);

  logic [3:0] half_reg; // half-period counter
  logic half_tick; // one-cycle enable at each half period

  assign half_tick = (half_reg == SYNC_HALF_CYCLES - 4'h1);

  // divider producing the half-period enable
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      half_reg <= 4'h0;
    end else begin
      half_reg <= half_tick ? 4'h0 : half_reg + 4'h1;
    end
  end

  // internal clock never stops, so the assembler keeps its timing
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      sync_int <= 1'b0;
    end else if (half_tick) begin
      sync_int <= ~sync_int;
    end
  end

  // pin: high marks q data unless inverted; static low when gated
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      sync_pin <= 1'b0;
    end else if (!sync_en) begin
      sync_pin <= 1'b0;
    end else begin
      sync_pin <= (half_tick ? ~sync_int : sync_int) ^ sync_inv;
    end
  end

endmodule

// file: rtl/scpll_top.sv
// scpll_top: configuration registers for the sync clock output, the
// ramp over-flag output and the reference clock path.
// assumes an Avalon-MM master on the same clock and an asynchronous
// reference clock pin; the PLL itself lives outside this block.
//
// Design decision made here: the Avalon-MM register port.

module scpll_top
  import scpll_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // avalon-mm slave
  input wire logic [7:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [31:0] readdata,
  output logic waitrequest,
  // reference clock pin
  input wire logic ref_clk_pin,
  // ramp generator over-flag
  input wire logic ramp_over_flag,
  output logic ramp_over_flag_out,
  output logic ramp_over_flag_oe,
  // sync clock
  output logic sync_clk_int,
  output logic sync_clk_pin,
  // pll and clock path controls
  output logic pll_enable,
  output logic sys_clk_from_pll,
  output logic pll_ref_tick,
  output logic doubler_on,
  output logic div_bypass
);

  import scpll_pkg::*;

  // bus handshake state
  scpll_bus_t bus_reg;
  scpll_bus_t bus_next;

  // software-visible registers
  logic [31:0] mode_out_reg; // mode_output_config
  logic [31:0] pll_clk_reg; // pll_clock_config

  // decoded access qualifiers
  logic req_w; // a request is presented
  logic take_w; // request completes at this edge
  logic wr_mode_w; // write to mode_output_config
  logic wr_pll_w; // write to pll_clock_config
  logic [31:0] pll_wr_w; // merged write value for pll_clock_config

  // divider reset launch, one cycle
  logic div_rst_reg;

  // field views
  logic ramp_over_en_w;
  logic sync_en_w;
  logic sync_inv_w;
  logic [1:0] div_code_w;
  logic dbl_en_w;
  logic dbl_edge_w;
  logic div_en_w;

  // submodule results
  logic div_busy_w;

  // read mux result
  logic [31:0] rd_mux_w;

  // status word built from live state
  logic [31:0] status_w;

  // ------------------------------------------------------------------
  // field views of the configuration registers
  // ------------------------------------------------------------------

  // over-flag output gate
  assign ramp_over_en_w = mode_out_reg[BIT_RAMP_OVER_EN];
  // sync pin gate and polarity
  assign sync_en_w = mode_out_reg[BIT_SYNC_EN];
  assign sync_inv_w = mode_out_reg[BIT_SYNC_INV];
  // reference path fields
  assign div_code_w = pll_clk_reg[BIT_DIV_LO +: 2];
  assign dbl_en_w = pll_clk_reg[BIT_DBL_EN];
  assign dbl_edge_w = pll_clk_reg[BIT_DBL_EDGE];
  assign div_en_w = pll_clk_reg[BIT_DIV_EN];

  // ------------------------------------------------------------------
  // avalon-mm handshake
  // ------------------------------------------------------------------

  // one wait state: the request is seen in idle, answered in ack
  assign req_w = read || write;
  assign take_w = (bus_reg == BUS_ACK) && req_w;

  // waitrequest drops only in the ack cycle; held high otherwise
  assign waitrequest = (bus_reg != BUS_ACK);

  // next handshake state
  always_comb begin
    bus_next = bus_reg;
    unique case (bus_reg)
      BUS_IDLE: begin
        // a pending request moves to the answer cycle
        if (req_w) begin
          bus_next = BUS_ACK;
        end
      end
      BUS_ACK: begin
        // the master releases after the answer edge
        bus_next = BUS_IDLE;
      end
      default: begin
        // illegal code recovers to idle
        bus_next = BUS_IDLE;
      end
    endcase
  end

  // handshake state register
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      bus_reg <= BUS_IDLE;
    end else begin
      bus_reg <= bus_next;
    end
  end

  // ------------------------------------------------------------------
  // register writes
  // ------------------------------------------------------------------

  // address decode for writes; unmapped addresses are ignored
  assign wr_mode_w = take_w && write && (address == ADR_MODE_OUT);
  assign wr_pll_w = take_w && write && (address == ADR_PLL_CLK);
  assign pll_wr_w = be_merge(pll_clk_reg, writedata, byteenable);

  // mode_output_config: only the three gate bits are kept, so the
  // reserved bit and open bits always read back as zero
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      mode_out_reg <= MODE_OUT_RST;
    end else if (wr_mode_w) begin
      mode_out_reg <= be_merge(mode_out_reg, writedata, byteenable) &
                      MODE_OUT_MASK;
    end
  end

  // pll_clock_config: divider reset bit is not stored, it launches
  // a pulse instead and reads back as zero
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      pll_clk_reg <= PLL_CLK_RST;
    end else if (wr_pll_w) begin
      pll_clk_reg <= pll_wr_w & PLL_CLK_MASK;
    end
  end

  // divider reset launch: a written 1 starts one reset sequence,
  // a written 0 does nothing
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      div_rst_reg <= 1'b0;
    end else begin
      div_rst_reg <= wr_pll_w && pll_wr_w[BIT_DIV_RST];
    end
  end

  // ------------------------------------------------------------------
  // register reads
  // ------------------------------------------------------------------

  // status shows live state of the clock path and sync clock
  always_comb begin
    status_w = 32'h0000_0000;
    status_w[ST_PLL_ON] = pll_enable;
    status_w[ST_DBL_ON] = doubler_on;
    status_w[ST_DIV_BYP] = div_bypass;
    status_w[ST_DIV_BUSY] = div_busy_w || div_rst_reg;
    status_w[ST_SYNC_INT] = sync_clk_int;
    status_w[ST_DIV_LO +: 2] = div_code_w;
  end

  // read decode; unmapped addresses read as zero
  always_comb begin
    rd_mux_w = 32'h0000_0000;
    if (address == ADR_MODE_OUT) begin
      rd_mux_w = mode_out_reg;
    end else if (address == ADR_PLL_CLK) begin
      rd_mux_w = pll_clk_reg;
    end else if (address == ADR_STATUS) begin
      rd_mux_w = status_w;
    end
  end

  // read data is captured as the request enters the ack cycle, so it
  // is already stable when waitrequest drops
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      readdata <= 32'h0000_0000;
    end else if ((bus_reg == BUS_IDLE) && read) begin
      readdata <= rd_mux_w;
    end
  end

  // ------------------------------------------------------------------
  // ramp over-flag output
  // ------------------------------------------------------------------

  // flag is registered so the pin never glitches; the enable is the
  // gate bit itself, so a disabled pin is not driven at all
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      ramp_over_flag_out <= 1'b0;
      ramp_over_flag_oe <= 1'b0;
    end else begin
      ramp_over_flag_out <= ramp_over_en_w && ramp_over_flag;
      ramp_over_flag_oe <= ramp_over_en_w;
    end
  end

  // ------------------------------------------------------------------
  // pll enable and clock source
  // ------------------------------------------------------------------

  // the pll outputs follow the register one cycle later; software is
  // expected to start oscillator calibration after enabling
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      pll_enable <= 1'b0;
      sys_clk_from_pll <= 1'b0;
    end else begin
      pll_enable <= pll_clk_reg[BIT_PLL_EN];
      sys_clk_from_pll <= pll_clk_reg[BIT_PLL_EN];
    end
  end

  // ------------------------------------------------------------------
  // reference path indicators
  // ------------------------------------------------------------------

  // edge bit alone does nothing; both bits are needed
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      doubler_on <= 1'b0;
      div_bypass <= 1'b1;
    end else begin
      doubler_on <= dbl_en_w && dbl_edge_w;
      div_bypass <= !div_en_w;
    end
  end

  // ------------------------------------------------------------------
  // reference divider
  // ------------------------------------------------------------------

  // the doubler uses the registered indicator so the divider sees a
  // clean change between edges
  scpll_ref_div u_ref_div (
    .ref_clk(ref_clk),
    .reset(reset),
    .ref_pin(ref_clk_pin),
    .div_en(div_en_w),
    .div_code(div_code_w),
    .dbl_on(doubler_on),
    .div_rst(div_rst_reg),
    .ref_tick(pll_ref_tick),
    .busy(div_busy_w)
  );

  // ------------------------------------------------------------------
  // sync clock generator
  // ------------------------------------------------------------------

  // internal sync clock keeps running even when the pin is gated
  scpll_sync_out u_sync_out (
    .ref_clk(ref_clk),
    .reset(reset),
    .sync_en(sync_en_w),
    .sync_inv(sync_inv_w),
    .sync_int(sync_clk_int),
    .sync_pin(sync_clk_pin)
  );

endmodule

// file: sim/scpll_checker.sv
// scpll_checker: concurrent checks on the ports of scpll_top.
// assumes the master holds a request until waitrequest is low.
module scpll_checker
  import scpll_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // bus
  input wire logic [7:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  input wire logic waitrequest,
  // outputs watched
  input wire logic ramp_over_flag,
  input wire logic ramp_over_flag_out,
  input wire logic ramp_over_flag_oe,
  input wire logic sync_clk_int,
  input wire logic sync_clk_pin,
  input wire logic pll_enable,
  input wire logic sys_clk_from_pll,
  input wire logic pll_ref_tick,
  input wire logic doubler_on,
  input wire logic div_bypass
);
  logic take; // a write completes at this edge
  logic [2:0] mode_reg; // shadow of bits 13, 11, 10
  logic [3:0] pll_reg; // shadow of bits 19..16
  logic [1:0] settle_reg; // edges since the last write, saturating
  logic quiet; // outputs have caught up with the shadows
  assign take = write && !waitrequest;
  assign quiet = settle_reg != 2'h0;

  // shadow mode bits; only lane 1 carries them
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      mode_reg <= 3'h2;
    end else if (take && address == ADR_MODE_OUT && byteenable[1]) begin
      mode_reg <= {writedata[13], writedata[11], writedata[10]};
    end
  end

  // shadow clock path bits; only lane 2 carries them
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      pll_reg <= 4'h0;
    end else if (take && address == ADR_PLL_CLK && byteenable[2]) begin
      pll_reg <= writedata[19:16];
    end
  end

  // registered outputs lag a write, so compare only once settled
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      settle_reg <= 2'h3;
    end else if (take) begin
      settle_reg <= 2'h0;
    end else if (settle_reg != 2'h3) begin
      settle_reg <= settle_reg + 2'h1;
    end
  end

  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);

  over_oe_a: assert property (quiet |->
    ramp_over_flag_oe == mode_reg[2])
    else $error("over-flag enable disagrees with bit 13");
  over_pass_a: assert property (quiet && mode_reg[2] |=>
    ramp_over_flag_out == $past(ramp_over_flag))
    else $error("over-flag output does not follow the flag");
  over_off_a: assert property (quiet && !mode_reg[2] |->
    !ramp_over_flag_out)
    else $error("over-flag output driven while disabled");
  sync_off_a: assert property (quiet && !mode_reg[1] |->
    !sync_clk_pin)
    else $error("sync pin not static low while disabled");
  sync_pol_a: assert property (quiet && mode_reg[1] |->
    sync_clk_pin == (sync_clk_int ^ mode_reg[0]))
    else $error("sync pin polarity wrong");
  sync_run_a: assert property ($rose(sync_clk_int) |->
    ##8 $rose(sync_clk_int))
    else $error("internal sync clock stopped or off period");
  pll_sel_a: assert property (quiet |-> pll_enable == pll_reg[2] &&
    sys_clk_from_pll == pll_reg[2])
    else $error("pll enable or clock select wrong");
  dbl_both_a: assert property (quiet |->
    doubler_on == (pll_reg[3] && pll_reg[0]))
    else $error("doubler state wrong");
  div_byp_a: assert property (quiet |-> div_bypass == !pll_reg[1])
    else $error("divider bypass wrong");
  bus_wait_a: assert property ((read || write) && waitrequest |=> !waitrequest)
    else $error("bus answer late");
  bus_once_a: assert property (!waitrequest |=> waitrequest)
    else $error("waitrequest low too long");

  cover property (take && address == ADR_PLL_CLK);
  cover property ($rose(sync_clk_int));
  cover property (pll_ref_tick);
  cover property (ramp_over_flag_out);
endmodule

bind scpll_top scpll_checker i_chk (.ref_clk, .reset, .address, .read,
  .write, .writedata, .byteenable, .waitrequest, .ramp_over_flag,
  .ramp_over_flag_out, .ramp_over_flag_oe, .sync_clk_int, .sync_clk_pin,
  .pll_enable, .sys_clk_from_pll, .pll_ref_tick, .doubler_on, .div_bypass);

// file: sim/scpll_top_test.sv
// scpll_top_test: self-checking bench for scpll_top.
// assumes the bus answers after one wait state and the pin is slow.
module scpll_top_test
  import scpll_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk = 1'b0;
  logic reset = 1'b1;
  logic [7:0] address = 8'h00;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [31:0] writedata = 32'h0;
  logic [3:0] byteenable = 4'hF;
  logic ref_clk_pin = 1'b0;
  logic ramp_over_flag = 1'b0;
  logic [31:0] readdata;
  logic waitrequest, ramp_over_flag_out, ramp_over_flag_oe;
  logic sync_clk_int, sync_clk_pin, pll_enable, sys_clk_from_pll;
  logic pll_ref_tick, doubler_on, div_bypass;
  logic [31:0] exp_q[$]; // expected read words, oldest first
  logic st_q[$]; // 1 where the read is of the status word
  logic [3:0] sync_ph = 4'h0; // bench count within a sync half period
  logic sync_model = 1'b0; // expected internal sync clock
  logic sync_prev = 1'b0; // expected sync clock one edge earlier
  logic [31:0] rnd = 32'hE052D90F; // random stream state
  int num_errors = 0;
  int samples_checked = 0;
  int tick_cnt = 0; // divided reference pulses seen

  scpll_top i_dut (.ref_clk, .reset, .address, .read, .write, .writedata,
    .byteenable, .readdata, .waitrequest, .ref_clk_pin, .ramp_over_flag,
    .ramp_over_flag_out, .ramp_over_flag_oe, .sync_clk_int, .sync_clk_pin,
    .pll_enable, .sys_clk_from_pll, .pll_ref_tick, .doubler_on,
    .div_bypass);

  // 250 MHz clock
  initial begin
    forever #2 ref_clk = ~ref_clk;
  end

  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction

  task check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // one bus cycle; held until waitrequest is seen low at an edge
  task bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
      input logic [3:0] be);
    @(posedge ref_clk);
    address <= a;
    write <= wr;
    read <= !wr;
    writedata <= d;
    byteenable <= be;
    // only the watchdog ends a wait that never gets its answer
    do begin
      @(posedge ref_clk);
    end while (waitrequest !== 1'b0);
    write <= 1'b0;
    read <= 1'b0;
  endtask

  // note the expected word, then read; the monitor compares
  task rd(input logic [7:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    st_q.push_back(1'b0);
    bus(1'b0, a, 32'h0, 4'hF);
  endtask

  // read the status word; its sync bit comes from the bench model
  task rd_st(input logic [31:0] e);
    exp_q.push_back(e);
    st_q.push_back(1'b1);
    bus(1'b0, ADR_STATUS, 32'h0, 4'hF);
  endtask

  // monitor: read results and divided reference pulses
  always @(posedge ref_clk) begin
    if (read === 1'b1 && waitrequest === 1'b0) begin
      check(readdata, exp_q.pop_front() |
        (st_q.pop_front() ? {27'h0, sync_prev, 4'h0} : 32'h0));
    end
    if (pll_ref_tick === 1'b1) tick_cnt++;
  end

  // sync clock model: one toggle per half period, counted from reset;
  // the status word samples it one edge before the answer edge
  always @(posedge ref_clk) begin
    if (reset) begin
      sync_ph <= 4'h0;
      sync_model <= 1'b0;
    end else if (sync_ph == SYNC_HALF_CYCLES - 4'h1) begin
      sync_ph <= 4'h0;
      sync_model <= ~sync_model;
    end else begin
      sync_ph <= sync_ph + 4'h1;
    end
    sync_prev <= sync_model;
  end

  task close_out;
    $display("checked %0d, mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // watchdog: the whole run needs some 4600 cycles
  initial begin
    repeat (20000) @(posedge ref_clk);
    num_errors++;
    close_out;
  end

  initial begin
    logic [31:0] d;
    repeat (6) @(posedge ref_clk);
    reset <= 1'b0;
    // reset values and an unmapped hole reading zero
    rd(ADR_MODE_OUT, MODE_OUT_RST);
    rd(ADR_PLL_CLK, PLL_CLK_RST);
    rd(8'h10, 32'h0);
    check(div_bypass, 1'b1);
    $display("test reset values done");
    // every mix of bits 13, 11, 10 with a random over-flag
    for (int i = 0; i < 8; i++) begin
      rnd = lfsr(rnd);
      d = {18'h0, i[2], 1'b0, i[1:0], 10'h0};
      bus(1'b1, ADR_MODE_OUT, d, 4'h2);
      ramp_over_flag <= rnd[0];
      rd(ADR_MODE_OUT, d);
      repeat (2) @(posedge ref_clk);
      check(ramp_over_flag_oe, i[2]);
      check(ramp_over_flag_out, i[2] & rnd[0]);
      repeat (8) begin
        @(posedge ref_clk);
        check(sync_clk_int, sync_model);
        check(sync_clk_pin, i[1] & (sync_model ^ i[0]));
      end
    end
    $display("test output gating done");
    // oscillator calibration sits outside this block
    for (int i = 0; i < 16; i++) begin
      d = {12'h0, i[3:0], 16'h0};
      bus(1'b1, ADR_PLL_CLK, d, 4'h4);
      rd(ADR_PLL_CLK, d);
      check(pll_enable, i[2]);
      check(sys_clk_from_pll, i[2]);
      check(doubler_on, i[3] & i[0]);
      check(div_bypass, !i[1]);
      rd_st({29'h0, !i[1], i[3] & i[0], i[2]});
    end
    $display("test clock path enables done");
    // 12 pin periods; leftover counts need the divider reset to clear
    for (int i = 0; i < 16; i++) begin
      d = {9'h0, 1'b1, i[1:0], i[3], 1'b0, i[2], i[3], 16'h0};
      bus(1'b1, ADR_PLL_CLK, d, 4'h4);
      rd(ADR_PLL_CLK, d & PLL_CLK_MASK);
      repeat (12) @(posedge ref_clk);
      tick_cnt = 0;
      repeat (12) begin
        repeat (10) @(posedge ref_clk);
        ref_clk_pin <= 1'b1;
        repeat (10) @(posedge ref_clk);
        ref_clk_pin <= 1'b0;
      end
      repeat (10) @(posedge ref_clk);
      check(tick_cnt, 32'((i[3] ? 24 : 12) >>
        (i[2] ? i[1:0] : 0)));
      rd_st({25'h0, i[1:0], 2'b00, !i[2], i[3], 1'b0});
    end
    $display("test divide ratios done");
    close_out;
  end
endmodule
